// file: core/rmi_pkg.sv
// Purpose: Shared constants and types for both ends of the reduced MII link
// Assumes: One reference clock times both directions at every line speed
// Notes: FIFO words carry one receive nibble plus its side flags
package rmi_pkg;

    // ==========================================================
    // Decimation at 10 Mbps
    // ==========================================================
    localparam int unsigned RMI_DECIM = 10;
    localparam logic [3:0] RMI_CNT_RST = 4'h0;
    localparam logic [3:0] RMI_DECIM_LAST = 4'(RMI_DECIM - 1);

    // ==========================================================
    // Receive elastic buffer
    // ==========================================================
    localparam int unsigned RMI_FIFO_DEPTH = 4;
    localparam int unsigned RMI_BITS_PER_WORD = 4;
    localparam logic [1:0] RMI_THR_RST = 2'h0;

    typedef struct packed {
        logic [3:0] data;
        logic err;
        logic last;
        logic single;
    } rmi_word_s;

    localparam int unsigned RMI_WORD_W = $bits(rmi_word_s);

    typedef enum logic [1:0] {
        RMI_IDLE,
        RMI_WAIT,
        RMI_DRAIN
    } rmi_rx_e;

    // Threshold code 0..3 selects 1..4 buffered nibbles (4..16 bits)
    function automatic logic [2:0] rmi_thr_words(input logic [1:0] thr);
        return {1'b0, thr} + 3'h1;
    endfunction

    // Advance of the one-in-ten pacing counter
    function automatic logic [3:0] rmi_pace_next(input logic [3:0] cnt);
        return (cnt == RMI_DECIM_LAST) ? RMI_CNT_RST : cnt + 4'h1;
    endfunction

endpackage

// file: core/rmi_if.sv
// Purpose: Wires between the transceiver end and the MAC end
// Assumes: Both ends run on the same reference clock
// Notes: No clocking block; the bench supplies the clock to both ends
`timescale 1ns/1ps
interface rmi_if;
    logic [1:0] txd;
    logic tx_en;
    logic [1:0] rxd;
    logic crs_dv;
    logic rx_dv;
    logic rx_er;

    modport phy (
        input txd,
        input tx_en,
        output rxd,
        output crs_dv,
        output rx_dv,
        output rx_er
    );

    modport mac (
        output txd,
        output tx_en,
        input rxd,
        input crs_dv,
        input rx_dv,
        input rx_er
    );
endinterface

// file: core/rmi_phy.sv
// Purpose: Transceiver end of the reduced MII link with receive elastic buffer
// Assumes: clk is the reference clock; line side is synchronous to clk
// Notes: Receive nibbles pass a 4-word FIFO before going out as dibits
//
// Overview of operation
// - Transmit dibits captured on reference clock edges
// - Receive dibits driven on same clock edges
// - Clock rate identical across all line modes
// - 10 Mbps: transmit dibit captured every tenth cycle
// - 10 Mbps: new receive dibit every tenth cycle
// - Separate receive valid beside carrier/valid output
// - Receive error output provided to MAC
// - Elastic buffer absorbs receive clock offset
// - Threshold codes select 4, 8, 12, 16 bits
// - Software picks threshold from maximum packet size
// - Packet limits assume equal clock accuracies
`timescale 1ns/1ps

// ==========================================================
// Elastic buffer FIFO
// ==========================================================
module rmi_fifo #(
    parameter int unsigned W = 7,
    parameter int unsigned D = 4
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data,
    output logic [$clog2(D):0] level
);
    localparam int unsigned AW = $clog2(D);
    localparam int unsigned CW = AW + 1;
    localparam logic [CW-1:0] FULL_CNT = CW'(D);
    localparam logic [CW-1:0] ONE_CNT = CW'(1);

    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [CW-1:0] cnt;
        logic can_take;
        logic has;
    } rmi_fifo_s;

    rmi_fifo_s s;
    rmi_fifo_s next_s;
    logic push;
    logic pop;

    assign in_ready = s.can_take;
    assign out_valid = s.has;
    assign out_data = s.mem[s.rp];
    assign level = s.cnt;

    always_comb begin
        next_s = s;
        push = in_valid && s.can_take;
        pop = out_ready && s.has;
        if (push) begin
            next_s.mem[s.wp] = in_data;
            next_s.wp = s.wp + AW'(1);
        end
        if (pop) begin
            next_s.rp = s.rp + AW'(1);
        end
        if (push && !pop) begin
            next_s.cnt = s.cnt + ONE_CNT;
        end else if (pop && !push) begin
            next_s.cnt = s.cnt - ONE_CNT;
        end
        next_s.can_take = (next_s.cnt != FULL_CNT);
        next_s.has = (next_s.cnt != '0);
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end
endmodule

// ==========================================================
// Transceiver end
// ==========================================================
module rmi_phy
    import rmi_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    rmi_if.phy mac,
    input wire logic speed_10,
    input wire logic [1:0] rx_buffer_start_threshold,
    input wire logic line_rx_valid,
    input wire logic [1:0] line_rx_dibit,
    input wire logic line_rx_err,
    input wire logic line_rx_last,
    output logic line_rx_ready,
    output logic tx_line_valid,
    output logic [1:0] tx_line_dibit
);
    typedef struct packed {
        rmi_rx_e st;
        rmi_word_s cur;
        logic sel;
        logic fin;
        logic end_seen;
        logic [3:0] rx_pc;
        logic [1:0] rxd;
        logic rx_dv;
        logic crs_dv;
        logic rx_er;
        logic [1:0] hold;
        logic hold_err;
        logic hold_full;
        logic [3:0] tx_pc;
        logic tx_valid;
        logic [1:0] tx_dibit;
    } rmi_phy_s;

    rmi_phy_s s;
    rmi_phy_s next_s;
    logic push;
    rmi_word_s push_word;
    logic pop;
    logic tick;
    logic fifo_ready;
    logic fifo_has;
    logic [RMI_WORD_W-1:0] fifo_raw;
    rmi_word_s fifo_word;
    logic [2:0] fifo_level;

    assign fifo_word = rmi_word_s'(fifo_raw);

    rmi_fifo #(
        .W(RMI_WORD_W),
        .D(RMI_FIFO_DEPTH)
    ) u_elastic (
        .clk(clk),
        .arst_n(arst_n),
        .in_valid(push),
        .in_ready(fifo_ready),
        .in_data(push_word),
        .out_valid(fifo_has),
        .out_ready(pop),
        .out_data(fifo_raw),
        .level(fifo_level)
    );

    assign mac.rxd = s.rxd;
    assign mac.rx_dv = s.rx_dv;
    assign mac.crs_dv = s.crs_dv;
    assign mac.rx_er = s.rx_er;
    assign line_rx_ready = fifo_ready;
    assign tx_line_valid = s.tx_valid;
    assign tx_line_dibit = s.tx_dibit;

    always_comb begin
        next_s = s;
        push = 1'b0;
        push_word = '0;
        pop = 1'b0;

        // ======================================================
        // Transmit capture
        // ======================================================
        next_s.tx_valid = 1'b0;
        if (mac.tx_en) begin
            if (!speed_10 || s.tx_pc == RMI_CNT_RST) begin
                next_s.tx_valid = 1'b1;
                next_s.tx_dibit = mac.txd;
            end
            next_s.tx_pc = rmi_pace_next(s.tx_pc);
        end else begin
            next_s.tx_pc = RMI_CNT_RST;
        end

        // ======================================================
        // Line receive: pair dibits into nibbles
        // ======================================================
        if (line_rx_valid && fifo_ready) begin
            if (s.hold_full || line_rx_last) begin
                push = 1'b1;
                push_word.data = s.hold_full ? {line_rx_dibit, s.hold} : {2'b00, line_rx_dibit};
                push_word.err = line_rx_err || (s.hold_full && s.hold_err);
                push_word.last = line_rx_last;
                push_word.single = !s.hold_full;
                next_s.hold_full = 1'b0;
            end else begin
                next_s.hold = line_rx_dibit;
                next_s.hold_err = line_rx_err;
                next_s.hold_full = 1'b1;
            end
        end

        // ======================================================
        // Buffer drain toward the MAC
        // ======================================================
        tick = !speed_10 || s.rx_pc == RMI_CNT_RST;
        unique case (s.st)
            RMI_IDLE: begin
                if (fifo_has || s.hold_full) begin
                    next_s.st = RMI_WAIT;
                    next_s.crs_dv = 1'b1;
                end
            end
            RMI_WAIT: begin
                if (fifo_level >= rmi_thr_words(rx_buffer_start_threshold) || s.end_seen) begin
                    next_s.st = RMI_DRAIN;
                    next_s.rx_pc = RMI_CNT_RST;
                    next_s.sel = 1'b0;
                    next_s.fin = 1'b0;
                end
            end
            RMI_DRAIN: begin
                next_s.rx_pc = rmi_pace_next(s.rx_pc);
                if (tick) begin
                    if (s.fin) begin
                        next_s.rx_dv = 1'b0;
                        next_s.crs_dv = 1'b0;
                        next_s.rx_er = 1'b0;
                        next_s.st = RMI_IDLE;
                    end else if (s.sel) begin
                        next_s.rxd = s.cur.data[3:2];
                        next_s.rx_er = s.cur.err;
                        next_s.sel = 1'b0;
                        next_s.fin = s.cur.last;
                    end else if (fifo_has) begin
                        pop = 1'b1;
                        next_s.end_seen = s.end_seen && !fifo_word.last;
                        next_s.cur = fifo_word;
                        next_s.rxd = fifo_word.data[1:0];
                        next_s.rx_er = fifo_word.err;
                        next_s.rx_dv = 1'b1;
                        next_s.crs_dv = 1'b1;
                        next_s.sel = !fifo_word.single;
                        next_s.fin = fifo_word.single && fifo_word.last;
                    end else begin
                        // Underrun: flag the dibit as bad and close the frame
                        next_s.rx_er = 1'b1;
                        next_s.rx_dv = 1'b1;
                        next_s.crs_dv = 1'b1;
                        next_s.fin = 1'b1;
                    end
                end
            end
        endcase

        // Set wins over the clear on popping a last word
        if (push && push_word.last) begin
            next_s.end_seen = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end
endmodule

// file: core/rmi_mac.sv
// Purpose: MAC end of the reduced MII link
// Assumes: clk is the same reference clock that times the transceiver
// Notes: One transmit dibit per slot; a slot is 1 or 10 cycles
`timescale 1ns/1ps
module rmi_mac
    import rmi_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    rmi_if.mac phy,
    input wire logic speed_10,
    input wire logic tx_valid,
    input wire logic [1:0] tx_dibit,
    input wire logic tx_last,
    output logic tx_ready,
    output logic rx_valid,
    output logic [1:0] rx_dibit,
    output logic rx_err,
    output logic rx_end
);
    typedef struct packed {
        logic tx_en;
        logic [1:0] txd;
        logic [3:0] tx_pc;
        logic cur_last;
        logic ready;
        logic [3:0] rx_pc;
        logic rx_dv_d;
        logic rx_valid;
        logic [1:0] rx_dibit;
        logic rx_err;
        logic rx_end;
    } rmi_mac_s;

    rmi_mac_s s;
    rmi_mac_s next_s;
    logic slot_end;

    assign phy.tx_en = s.tx_en;
    assign phy.txd = s.txd;
    assign tx_ready = s.ready;
    assign rx_valid = s.rx_valid;
    assign rx_dibit = s.rx_dibit;
    assign rx_err = s.rx_err;
    assign rx_end = s.rx_end;

    always_comb begin
        next_s = s;

        // ======================================================
        // Transmit: hold each dibit for one slot
        // ======================================================
        slot_end = !s.tx_en || !speed_10 || s.tx_pc == RMI_DECIM_LAST;
        if (s.ready && tx_valid) begin
            next_s.tx_en = 1'b1;
            next_s.txd = tx_dibit;
            next_s.tx_pc = RMI_CNT_RST;
            next_s.cur_last = tx_last;
        end else if (slot_end) begin
            next_s.tx_en = 1'b0;
            next_s.tx_pc = RMI_CNT_RST;
        end else begin
            next_s.tx_pc = s.tx_pc + 4'h1;
        end
        // Ready only in the last cycle of a slot or while idle; one idle gap after the last
        if (next_s.tx_en) begin
            next_s.ready = !next_s.cur_last
                && (!speed_10 || next_s.tx_pc == RMI_DECIM_LAST);
        end else begin
            next_s.ready = 1'b1;
        end

        // ======================================================
        // Receive sampling
        // ======================================================
        next_s.rx_valid = 1'b0;
        next_s.rx_dv_d = phy.rx_dv;
        next_s.rx_end = s.rx_dv_d && !phy.rx_dv;
        if (phy.rx_dv) begin
            if (s.rx_pc == RMI_CNT_RST) begin
                next_s.rx_valid = 1'b1;
                next_s.rx_dibit = phy.rxd;
                next_s.rx_err = phy.rx_er;
            end
            next_s.rx_pc = speed_10 ? rmi_pace_next(s.rx_pc) : RMI_CNT_RST;
        end else begin
            next_s.rx_pc = RMI_CNT_RST;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end
endmodule

// file: test/rmi_monitor.sv
// Purpose: Checker on the wires joining both ends
// Assumes: Speed stays steady within a frame
// Notes: Slot counters restart on each idle cycle
`timescale 1ns/1ps
module rmi_monitor (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic speed_10,
    input wire logic [1:0] txd,
    input wire logic tx_en,
    input wire logic [1:0] rxd,
    input wire logic crs_dv,
    input wire logic rx_dv,
    input wire logic rx_er
);
    logic [3:0] tc;
    logic [3:0] rc;

    // ==========================================================
    // Slot counters
    // ==========================================================
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tc <= 4'h0;
            rc <= 4'h0;
        end else begin
            tc <= (!tx_en || tc == 4'h9) ? 4'h0 : tc + 4'h1;
            rc <= (!rx_dv || rc == 4'h9) ? 4'h0 : rc + 4'h1;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    a_tx_slot_hold: assert property (speed_10 && tx_en && tc != 4'h0 |-> $stable(txd))
        else $error("txd changed inside a slot");
    a_tx_slot_end: assert property (speed_10 && $fell(tx_en) |-> tc == 4'h0)
        else $error("tx_en fell inside a slot");
    a_rx_slot_hold: assert property (speed_10 && rx_dv && rc != 4'h0 |-> $stable(rxd))
        else $error("rxd changed inside a slot");
    a_rx_slot_end: assert property (speed_10 && $fell(rx_dv) |-> rc == 4'h0)
        else $error("rx_dv fell inside a slot");
    a_dv_in_crs: assert property (rx_dv |-> crs_dv)
        else $error("rx_dv high without crs_dv");
    a_drop_together: assert property ($fell(rx_dv) |-> $fell(crs_dv) && !rx_er)
        else $error("rx_dv and crs_dv did not drop together");
    a_er_in_frame: assert property (rx_er |-> rx_dv)
        else $error("rx_er outside a frame");
    a_crs_leads: assert property ($rose(crs_dv) |-> !rx_dv)
        else $error("rx_dv rose with crs_dv");
    a_drain_starts: assert property ($rose(crs_dv) |-> ##[1:200] rx_dv)
        else $error("buffer drain never started");
endmodule

// file: test/testbench.sv
// Purpose: Random frames both ways across the joined ends
// Assumes: Line dibits offered back to back
// Notes: Each speed runs every threshold code
`timescale 1ns/1ps
module testbench;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic speed_10 = 1'b0;
    logic [1:0] thr = 2'h0;
    logic lv = 1'b0;
    logic [1:0] ld = 2'h0;
    logic le = 1'b0;
    logic ll = 1'b0;
    logic tv = 1'b0;
    logic [1:0] td = 2'h0;
    logic tl = 1'b0;
    logic lrdy, tlv, trdy, rv, rerr, rend;
    logic [1:0] tld, rd;
    int bad_count = 0;
    int compares = 0;
    int cyc = 0;
    int slot, t0, t1, last_tx, last_rx, en_cyc, dv_cyc, ends;
    logic full;
    logic [1:0] dd[20];
    logic ee[20];
    logic [2:0] exp_rx[$];
    logic [2:0] got_rx[$];
    logic [1:0] exp_tx[$];
    logic [1:0] got_tx[$];

    rmi_if link();
    rmi_phy u_rmi_phy (.clk(clk), .arst_n(arst_n), .mac(link), .speed_10(speed_10),
        .rx_buffer_start_threshold(thr), .line_rx_valid(lv), .line_rx_dibit(ld),
        .line_rx_err(le), .line_rx_last(ll), .line_rx_ready(lrdy),
        .tx_line_valid(tlv), .tx_line_dibit(tld));
    rmi_mac u_rmi_mac (.clk(clk), .arst_n(arst_n), .phy(link), .speed_10(speed_10),
        .tx_valid(tv), .tx_dibit(td), .tx_last(tl), .tx_ready(trdy), .rx_valid(rv),
        .rx_dibit(rd), .rx_err(rerr), .rx_end(rend));
    rmi_monitor u_rmi_monitor (.clk(clk), .arst_n(arst_n), .speed_10(speed_10),
        .txd(link.txd), .tx_en(link.tx_en), .rxd(link.rxd), .crs_dv(link.crs_dv),
        .rx_dv(link.rx_dv), .rx_er(link.rx_er));

    always #2 clk = ~clk;

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            bad_count++;
            $display("Error %s expected %0h seen %0h", nm, e, g);
        end
    endtask

    task automatic final_report();
        $display("Compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Word error covers both dibits of a nibble
    function automatic logic [2:0] rx_word(input int i, input int m);
        return {ee[i] | (((i ^ 1) < m) ? ee[i ^ 1] : 1'b0), dd[i]};
    endfunction

    // ==========================================================
    // Collector
    // ==========================================================
    always @(posedge clk) begin
        cyc++;
        if (lv && lrdy && t0 < 0) t0 = cyc;
        if (lv && !lrdy) full = 1'b1;
        if (link.rx_dv && dv_cyc == 0) t1 = cyc;
        if (link.tx_en) en_cyc++;
        if (link.rx_dv) dv_cyc++;
        if (rend) ends++;
        if (tlv) begin
            if (last_tx >= 0) chk("tx_gap", slot, cyc - last_tx);
            last_tx = cyc;
            got_tx.push_back(tld);
        end
        if (rv) begin
            if (last_rx >= 0) chk("rx_gap", slot, cyc - last_rx);
            last_rx = cyc;
            got_rx.push_back({rerr, rd});
        end
    end

    task automatic frame(input logic sp, input logic [1:0] th);
        int n;
        int m;
        n = 6 + $urandom % 8;
        m = 10 + $urandom % 7;
        speed_10 = sp;
        thr = th;
        slot = sp ? 10 : 1;
        t0 = -1;
        last_tx = -1;
        last_rx = -1;
        en_cyc = 0;
        dv_cyc = 0;
        ends = 0;
        full = 1'b0;
        for (int i = 0; i < m; i++) begin
            dd[i] = 2'($urandom);
            ee[i] = ($urandom % 6) == 0;
        end
        for (int i = 0; i < m; i++) exp_rx.push_back(rx_word(i, m));
        fork
            begin
                for (int i = 0; i < n; i++) begin
                    tv = 1'b1;
                    td = 2'($urandom);
                    tl = (i == n - 1);
                    exp_tx.push_back(td);
                    @(posedge clk);
                    while (!trdy) @(posedge clk);
                    #1;
                end
                tv = 1'b0;
            end
            begin
                for (int i = 0; i < m; i++) begin
                    lv = 1'b1;
                    ld = dd[i];
                    le = ee[i];
                    ll = (i == m - 1);
                    @(posedge clk);
                    while (!lrdy) @(posedge clk);
                    #1;
                end
                lv = 1'b0;
            end
        join
        while (ends == 0 || got_tx.size() < n || link.tx_en) @(posedge clk);
        #1;
        chk("tx_en_cycles", n * slot, en_cyc);
        chk("rx_dv_cycles", m * slot, dv_cyc);
        chk("rx_ends", 1, ends);
        chk("start_latency", 2 * th + 4, t1 - t0);
        if (sp) chk("refused", 1, full);
        chk("tx_count", n, got_tx.size());
        chk("rx_count", m, got_rx.size());
        foreach (got_tx[i]) chk("tx_dibit", exp_tx[i], got_tx[i]);
        foreach (got_rx[i]) chk("rx_word", exp_rx[i], got_rx[i]);
        exp_tx.delete();
        got_tx.delete();
        exp_rx.delete();
        got_rx.delete();
    endtask

    initial begin
        void'($urandom(81));
        repeat (5) @(posedge clk);
        #1;
        arst_n = 1'b1;
        @(posedge clk);
        #1;
        for (int s = 0; s < 2; s++) begin
            for (int t = 0; t < 4; t++) begin
                frame(s[0], t[1:0]);
            end
        end
        final_report();
    end

    initial begin
        #100000;
        bad_count++;
        $display("Error watchdog expected done seen timeout");
        final_report();
    end
endmodule
